// [hsf_top.sv]
// hoist supervisory functions: slack cable, direction, upper limits
// assumes plain register port, limit contacts asynchronous, torque/speed on core clock
// Functional notes
// - slack flag is set while torque is below the programmed threshold.
// - slack flag requires the condition to persist for the qualify time.
// - five output selectors hold 8-bit codes; code 36 routes slack.
// - an output with code 12 is high while speed feedback is positive.
// - an output with code 13 is high while speed feedback is negative.
// - direction outputs depend only on the feedback sign, not run command.
// - slow-down upper limit enabled by input code 0a or extension config 7111.
// - slow-down limit decelerates to low speed with primary decel and blocks up.
// - stop upper limit enabled by input code 0b or extension config 7112.
// - stop limit halts with primary decel and blocks upward motion.
// - limit contacts are normally closed; an open contact means limit reached.
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module hsf_top
    import hsf_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // drive estimates
    input wire logic signed [15:0] torque_monitor_value_in,
    input wire logic signed [15:0] speed_feedback_in,
    input wire logic run_up_cmd_in,
    input wire logic run_down_cmd_in,
    // terminals
    input wire logic [hsf_pkg::HSF_NUM_ISEL-1:0] input_terminal_in,
    input wire logic extension_terminal_one_in,
    input wire logic extension_terminal_two_in,
    output logic [hsf_pkg::HSF_NUM_OSEL-1:0] optocoupler_output_out,
    // motion control
    output logic up_allowed_out,
    output logic down_allowed_out,
    output logic use_low_speed_reference_out,
    output logic stop_with_primary_decel_out,
    output logic slow_with_primary_decel_out,
    output logic irq_out
);
    import hsf_pkg::*;

    logic [15:0] thresh_r, thresh_nxt;
    logic [7:0] qtime_r, qtime_nxt;
    logic [7:0] osel_r [HSF_NUM_OSEL];
    logic [7:0] osel_nxt [HSF_NUM_OSEL];
    logic [7:0] isel_r [HSF_NUM_ISEL];
    logic [7:0] isel_nxt [HSF_NUM_ISEL];
    logic [15:0] extcfg_r, extcfg_nxt;
    logic [2:0] irq_r, irq_nxt;
    logic [2:0] mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [HSF_NUM_ISEL+1:0] sync1_r, sync2_r;
    logic [31:0] qdiv_r, qdiv_nxt;
    logic [7:0] qcnt_r, qcnt_nxt;
    logic slack_r, slack_nxt;
    logic [HSF_NUM_OSEL-1:0] out_r, out_nxt;
    logic ul_slow_prev_r, ul_stop_prev_r;
    hsf_mode_type mode_r, mode_nxt;
    logic below, ul_slow, ul_stop;
    logic [2:0] events;

    // register writes and irq bookkeeping
    always_comb begin
        thresh_nxt = thresh_r;
        qtime_nxt = qtime_r;
        extcfg_nxt = extcfg_r;
        mask_nxt = mask_r;
        rdata_nxt = 32'h0;
        irq_nxt = irq_r;
        for (int i = 0; i < HSF_NUM_OSEL; i++) begin
            osel_nxt[i] = osel_r[i];
        end
        for (int i = 0; i < HSF_NUM_ISEL; i++) begin
            isel_nxt[i] = isel_r[i];
        end
        if (reg_wr_in) begin
            if (reg_addr_in == HSF_OFS_THRESH) begin
                thresh_nxt = (reg_wdata_in[15:0] > HSF_THRESH_MAX) ? HSF_THRESH_MAX
                                                                  : reg_wdata_in[15:0];
            end
            if (reg_addr_in == HSF_OFS_QTIME) begin
                qtime_nxt = reg_wdata_in[7:0];
            end
            if (reg_addr_in == HSF_OFS_EXTCFG) begin
                extcfg_nxt = reg_wdata_in[15:0];
            end
            if (reg_addr_in == HSF_OFS_MASK) begin
                mask_nxt = reg_wdata_in[2:0];
            end
            for (int i = 0; i < HSF_NUM_OSEL; i++) begin
                if (reg_addr_in == HSF_OFS_OSEL0 + 8'(4 * i)) begin
                    osel_nxt[i] = reg_wdata_in[7:0];
                end
            end
            for (int i = 0; i < HSF_NUM_ISEL; i++) begin
                if (reg_addr_in == HSF_OFS_ISEL0 + 8'(4 * i)) begin
                    isel_nxt[i] = reg_wdata_in[7:0];
                end
            end
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                HSF_OFS_CTRL: rdata_nxt = {28'h0, up_allowed_out, down_allowed_out,
                                           mode_r};
                HSF_OFS_THRESH: rdata_nxt = {16'h0, thresh_r};
                HSF_OFS_QTIME: rdata_nxt = {24'h0, qtime_r};
                HSF_OFS_EXTCFG: rdata_nxt = {16'h0, extcfg_r};
                HSF_OFS_STATUS: rdata_nxt = {26'h0, out_r[0], slack_r, ul_stop, ul_slow,
                                             speed_feedback_in[15], slack_r};
                HSF_OFS_IRQ: rdata_nxt = {29'h0, irq_r};
                HSF_OFS_MASK: rdata_nxt = {29'h0, mask_r};
                default: begin
                    rdata_nxt = 32'h0;
                    for (int i = 0; i < HSF_NUM_OSEL; i++) begin
                        if (reg_addr_in == HSF_OFS_OSEL0 + 8'(4 * i)) begin
                            rdata_nxt = {24'h0, osel_r[i]};
                        end
                    end
                    for (int i = 0; i < HSF_NUM_ISEL; i++) begin
                        if (reg_addr_in == HSF_OFS_ISEL0 + 8'(4 * i)) begin
                            rdata_nxt = {24'h0, isel_r[i]};
                        end
                    end
                end
            endcase
            if (reg_addr_in == HSF_OFS_IRQ) begin
                irq_nxt = 3'h0;
            end
        end
        // set wins over read clear
        irq_nxt = irq_nxt | events;
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            thresh_r <= HSF_THRESH_RST;
            qtime_r <= HSF_QTIME_RST;
            extcfg_r <= HSF_EXTCFG_RST;
            mask_r <= 3'h0;
            rdata_r <= 32'h0;
            irq_r <= HSF_IRQ_RST;
            for (int i = 0; i < HSF_NUM_OSEL; i++) begin
                osel_r[i] <= HSF_OSEL_RST[i];
            end
            for (int i = 0; i < HSF_NUM_ISEL; i++) begin
                isel_r[i] <= HSF_ISEL_RST;
            end
        end else begin
            thresh_r <= thresh_nxt;
            qtime_r <= qtime_nxt;
            extcfg_r <= extcfg_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
            osel_r <= osel_nxt;
            isel_r <= isel_nxt;
        end
    end

    // contact synchronisers
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sync1_r <= '1;
            sync2_r <= '1;
        end else begin
            sync1_r <= {extension_terminal_two_in, extension_terminal_one_in,
                        input_terminal_in};
            sync2_r <= sync1_r;
        end
    end

    // limit decode from selectors and extension config
    always_comb begin
        ul_slow = 1'b0;
        ul_stop = 1'b0;
        for (int i = 0; i < HSF_NUM_ISEL; i++) begin
            if (isel_r[i] == HSF_ICODE_UL_SLOW && !sync2_r[i]) begin
                ul_slow = 1'b1;
            end
            if (isel_r[i] == HSF_ICODE_UL_STOP && !sync2_r[i]) begin
                ul_stop = 1'b1;
            end
        end
        if (extcfg_r == HSF_EXT_UL_SLOW && !sync2_r[HSF_NUM_ISEL]) begin
            ul_slow = 1'b1;
        end
        if (extcfg_r == HSF_EXT_UL_STOP && !sync2_r[HSF_NUM_ISEL+1]) begin
            ul_stop = 1'b1;
        end
    end

    // slack detect and qualify timer
    always_comb begin
        below = (torque_monitor_value_in < $signed({1'b0, thresh_r[14:0]}));
        qdiv_nxt = qdiv_r;
        qcnt_nxt = qcnt_r;
        slack_nxt = 1'b0;
        if (!below) begin
            qdiv_nxt = 32'h0;
            qcnt_nxt = 8'h0;
        end else if (qcnt_r >= qtime_r) begin
            slack_nxt = 1'b1;
        end else if (qdiv_r == 32'(HSF_QSTEP_CYC - 1)) begin
            qdiv_nxt = 32'h0;
            qcnt_nxt = qcnt_r + 8'h1;
        end else begin
            qdiv_nxt = qdiv_r + 32'h1;
        end
    end

    // output routing
    always_comb begin
        for (int i = 0; i < HSF_NUM_OSEL; i++) begin
            unique case (osel_r[i])
                HSF_OCODE_SLACK: out_nxt[i] = slack_nxt;
                HSF_OCODE_FWD: out_nxt[i] = !speed_feedback_in[15] && |speed_feedback_in;
                HSF_OCODE_REV: out_nxt[i] = speed_feedback_in[15];
                default: out_nxt[i] = 1'b0;
            endcase
        end
    end

    // limit motion mode
    always_comb begin
        mode_nxt = HSF_RUN_NORMAL;
        if (ul_stop) begin
            mode_nxt = HSF_RUN_STOP;
        end else if (ul_slow) begin
            mode_nxt = HSF_RUN_SLOW;
        end
        events = {ul_stop && !ul_stop_prev_r, ul_slow && !ul_slow_prev_r,
                  slack_nxt && !slack_r};
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            qdiv_r <= 32'h0;
            qcnt_r <= 8'h0;
            slack_r <= 1'b0;
            out_r <= '0;
            mode_r <= HSF_RUN_NORMAL;
            ul_slow_prev_r <= 1'b0;
            ul_stop_prev_r <= 1'b0;
        end else begin
            qdiv_r <= qdiv_nxt;
            qcnt_r <= qcnt_nxt;
            slack_r <= slack_nxt;
            out_r <= out_nxt;
            mode_r <= mode_nxt;
            ul_slow_prev_r <= ul_slow;
            ul_stop_prev_r <= ul_stop;
        end
    end

    assign reg_rdata_out = rdata_r;
    assign optocoupler_output_out = out_r;
    assign up_allowed_out = (mode_r == HSF_RUN_NORMAL) && run_up_cmd_in;
    assign down_allowed_out = run_down_cmd_in;
    assign use_low_speed_reference_out = (mode_r == HSF_RUN_SLOW);
    assign slow_with_primary_decel_out = (mode_r == HSF_RUN_SLOW);
    assign stop_with_primary_decel_out = (mode_r == HSF_RUN_STOP);
    assign irq_out = |(irq_r & mask_r);
endmodule : hsf_top

// [hsf_pkg.sv]
// hoist supervisory functions: shared constants and types
// assumes 100 mhz core clock, torque in 0.01 percent units
package hsf_pkg;
    localparam int HSF_CLK_MHZ = 100;
    localparam int HSF_CLK_HZ = 100000000;
    // register offsets
    localparam logic [7:0] HSF_OFS_CTRL = 8'h00;
    localparam logic [7:0] HSF_OFS_THRESH = 8'h04;
    localparam logic [7:0] HSF_OFS_QTIME = 8'h08;
    localparam logic [7:0] HSF_OFS_OSEL0 = 8'h0c;
    localparam logic [7:0] HSF_OFS_ISEL0 = 8'h20;
    localparam logic [7:0] HSF_OFS_EXTCFG = 8'h30;
    localparam logic [7:0] HSF_OFS_STATUS = 8'h34;
    localparam logic [7:0] HSF_OFS_IRQ = 8'h38;
    localparam logic [7:0] HSF_OFS_MASK = 8'h3c;
    localparam int HSF_NUM_OSEL = 5;
    localparam int HSF_NUM_ISEL = 4;
    // reset values and threshold clamp
    localparam logic [15:0] HSF_THRESH_RST = 16'h2710;
    localparam logic [15:0] HSF_THRESH_MAX = 16'h7530;
    localparam logic [7:0] HSF_QTIME_RST = 8'h00;
    localparam logic [7:0] HSF_OSEL_RST [HSF_NUM_OSEL] = '{8'h3f, 8'h47, 8'h60, 8'hbd, 8'h3f};
    localparam logic [7:0] HSF_ISEL_RST = 8'h03;
    localparam logic [15:0] HSF_EXTCFG_RST = 16'h711a;
    localparam logic [2:0] HSF_IRQ_RST = 3'h0;
    // function codes
    localparam logic [7:0] HSF_OCODE_SLACK = 8'h36;
    localparam logic [7:0] HSF_OCODE_FWD = 8'h12;
    localparam logic [7:0] HSF_OCODE_REV = 8'h13;
    localparam logic [7:0] HSF_ICODE_UL_SLOW = 8'h0a;
    localparam logic [7:0] HSF_ICODE_UL_STOP = 8'h0b;
    localparam logic [15:0] HSF_EXT_UL_SLOW = 16'h7111;
    localparam logic [15:0] HSF_EXT_UL_STOP = 16'h7112;
    // qualify time step is 10 ms
    localparam int HSF_QSTEP_MS = 10;
    localparam int HSF_QSTEP_CYC = HSF_QSTEP_MS * (HSF_CLK_HZ / 1000);
    // irq bit positions; status has slack at bit 0, ul_slow at bit 2, ul_stop at bit 3
    localparam int HSF_BIT_SLACK = 0;
    localparam int HSF_BIT_UL_SLOW = 1;
    localparam int HSF_BIT_UL_STOP = 2;
    typedef enum logic [1:0] {HSF_RUN_NORMAL, HSF_RUN_SLOW, HSF_RUN_STOP} hsf_mode_type;
endpackage : hsf_pkg

// [hsf_top_properties.sv]
// port checker for the hoist supervisory block
// assumes bind from the bench; extension config mirrored from the write port
`timescale 1ns/1ps
module hsf_props
    import hsf_pkg::*;
(
    // clock, reset, register port
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    // commands and limit terminals
    input wire logic run_up_cmd_in,
    input wire logic run_down_cmd_in,
    input wire logic extension_terminal_one_in,
    input wire logic extension_terminal_two_in,
    // motion outputs
    input wire logic up_allowed_out,
    input wire logic down_allowed_out,
    input wire logic use_low_speed_reference_out,
    input wire logic stop_with_primary_decel_out,
    input wire logic slow_with_primary_decel_out
);
    logic [15:0] ext_r;
    logic [15:0] ext_nxt;
    // mirror of the extension config
    always_comb begin
        ext_nxt = (reg_wr_in && reg_addr_in == HSF_OFS_EXTCFG) ? reg_wdata_in[15:0] : ext_r;
    end
    always_ff @(posedge core_clk_in) begin
        ext_r <= rst_in ? HSF_EXTCFG_RST : ext_nxt;
    end
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    AST_DOWN_FOLLOWS: assert property (down_allowed_out == run_down_cmd_in)
        else $error("down permission differs from command");
    AST_UP_BLOCKED: assert property ((use_low_speed_reference_out || stop_with_primary_decel_out)
        |-> !up_allowed_out) else $error("up allowed at a limit");
    AST_UP_PASS: assert property (!(use_low_speed_reference_out || stop_with_primary_decel_out)
        |-> up_allowed_out == run_up_cmd_in) else $error("up permission wrong");
    AST_SLOW_PAIR: assert property (use_low_speed_reference_out == slow_with_primary_decel_out)
        else $error("low speed and slow decel disagree");
    AST_STOP_WINS: assert property (stop_with_primary_decel_out |-> !use_low_speed_reference_out)
        else $error("stop and slow together");
    AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside read slot");
    AST_UL_STOP: assert property ((ext_r == HSF_EXT_UL_STOP && !extension_terminal_two_in)[*5]
        |-> stop_with_primary_decel_out) else $error("open stop contact ignored");
    AST_UL_SLOW: assert property ((ext_r == HSF_EXT_UL_SLOW && !extension_terminal_one_in)[*5]
        |-> use_low_speed_reference_out || stop_with_primary_decel_out) else $error("slow ignored");
endmodule : hsf_props

// [hsf_limit_sw.sv]
// limit switch bank beside the hoist block
// assumes open requests from the bench
`timescale 1ns/1ps
module hsf_limit_sw (
    // open requests: 3:0 selector inputs, 4 terminal one, 5 terminal two
    input wire logic [5:0] open_in,
    // contact levels, 1 closed
    output logic [3:0] term_out,
    output logic ext_one_out,
    output logic ext_two_out
);
    assign term_out = ~open_in[3:0];
    assign ext_one_out = ~open_in[4];
    assign ext_two_out = ~open_in[5];
endmodule : hsf_limit_sw

// [tb_top.sv]
// bench for the hoist block: registers, direction, slack, upper limits
// assumes the limit switch model and the bound port checker
`timescale 1ns/1ps
module tb_top;
    import hsf_pkg::*;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic signed [15:0] torque = 16'sh2710;
    logic signed [15:0] speed = 16'sh0000;
    logic up_cmd = 1'b0;
    logic down_cmd = 1'b0;
    logic [5:0] open_req = 6'h00;
    logic [31:0] rdata;
    logic [3:0] term;
    logic [4:0] opto;
    logic ext_one, ext_two, up_ok, down_ok, low_ref, stop_dec, slow_dec, irq;
    int bad_count = 0;
    int checks = 0;
    always #5 core_clk_in = ~core_clk_in;
    hsf_limit_sw u_sw (.open_in(open_req), .term_out(term), .ext_one_out(ext_one),
        .ext_two_out(ext_two));
    hsf_top dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .torque_monitor_value_in(torque), .speed_feedback_in(speed), .run_up_cmd_in(up_cmd),
        .run_down_cmd_in(down_cmd), .input_terminal_in(term), .extension_terminal_one_in(ext_one),
        .extension_terminal_two_in(ext_two), .optocoupler_output_out(opto),
        .up_allowed_out(up_ok), .down_allowed_out(down_ok), .use_low_speed_reference_out(low_ref),
        .stop_with_primary_decel_out(stop_dec), .slow_with_primary_decel_out(slow_dec),
        .irq_out(irq));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1;
        chk(name, rdata, exp);
    endtask : rd_chk
    task automatic lim(input logic [5:0] o);
        @(posedge core_clk_in);
        open_req <= o;
        cyc(6);
    endtask : lim
    task automatic t_regs;
        chk("irq_rst", 32'({irq, opto}), 32'h0);
        rd_chk("thresh", HSF_OFS_THRESH, 32'h2710);
        rd_chk("qtime", HSF_OFS_QTIME, 32'h0);
        rd_chk("extcfg", HSF_OFS_EXTCFG, 32'h711a);
        rd_chk("unmapped", 8'h40, 32'h0);
        for (int i = 0; i < 5; i++) begin
            rd_chk("osel", HSF_OFS_OSEL0 + 8'(4 * i), {24'h0, HSF_OSEL_RST[i]});
        end
        for (int i = 0; i < 4; i++) begin
            rd_chk("isel", HSF_OFS_ISEL0 + 8'(4 * i), 32'h03);
        end
        // long qualify first so the clamped threshold raises no slack event
        wr_reg(HSF_OFS_QTIME, 32'hff);
        rd_chk("qmax", HSF_OFS_QTIME, 32'hff);
        wr_reg(HSF_OFS_THRESH, 32'h7531);
        rd_chk("clamp", HSF_OFS_THRESH, 32'h7530);
        wr_reg(HSF_OFS_THRESH, 32'h2710);
        wr_reg(HSF_OFS_QTIME, 32'h0);
    endtask : t_regs
    task automatic t_dir;
        logic [15:0] sp [4] = '{16'h0001, 16'hffff, 16'h0000, 16'h8000};
        wr_reg(HSF_OFS_OSEL0, 32'h12);
        wr_reg(HSF_OFS_OSEL0 + 8'h04, 32'h13);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_in);
            speed <= sp[i];
            up_cmd <= (i == 1);
            down_cmd <= (i == 0);
            cyc(4);
            chk("fwd", 32'(opto[0]), 32'(i == 0));
            chk("rev", 32'(opto[1]), 32'(i == 1 || i == 3));
        end
    endtask : t_dir
    task automatic t_slack;
        wr_reg(HSF_OFS_OSEL0 + 8'h08, 32'h36);
        wr_reg(HSF_OFS_THRESH, 32'h0bb8);
        wr_reg(HSF_OFS_MASK, 32'h1);
        @(posedge core_clk_in);
        torque <= 16'sh0bb8;
        cyc(6);
        chk("slack_eq", 32'({opto[2], irq}), 32'h0);
        wr_reg(HSF_OFS_QTIME, 32'h1);
        @(posedge core_clk_in);
        torque <= 16'sh0bb7;
        cyc(20);
        chk("slack_hold", 32'({opto[2], irq}), 32'h0);
        wr_reg(HSF_OFS_QTIME, 32'h0);
        cyc(6);
        chk("slack", 32'({opto[2], irq}), 32'h3);
        rd_chk("irq_bits", HSF_OFS_IRQ, 32'h1);
        chk("irq_clr", 32'(irq), 32'h0);
        rd_chk("status", HSF_OFS_STATUS, 32'h13);
        @(posedge core_clk_in);
        torque <= 16'sh2710;
    endtask : t_slack
    task automatic t_limit;
        @(posedge core_clk_in);
        up_cmd <= 1'b1;
        down_cmd <= 1'b1;
        wr_reg(HSF_OFS_MASK, 32'h6);
        lim(6'h30);
        chk("no_cfg", 32'({low_ref, stop_dec}), 32'h0);
        lim(6'h00);
        wr_reg(HSF_OFS_EXTCFG, 32'h7112);
        lim(6'h20);
        chk("stop", 32'({stop_dec, up_ok, down_ok, irq}), 32'hb);
        rd_chk("irq_stop", HSF_OFS_IRQ, 32'h4);
        rd_chk("ctrl", HSF_OFS_CTRL, 32'h6);
        lim(6'h00);
        chk("stop_clr", 32'({stop_dec, up_ok}), 32'h1);
        wr_reg(HSF_OFS_EXTCFG, 32'h7111);
        lim(6'h10);
        chk("slow", 32'({low_ref, slow_dec, up_ok, down_ok}), 32'hd);
        lim(6'h00);
        wr_reg(HSF_OFS_EXTCFG, 32'h711a);
        wr_reg(HSF_OFS_ISEL0, 32'h0a);
        wr_reg(HSF_OFS_ISEL0 + 8'h04, 32'h0b);
        lim(6'h01);
        chk("isel_slow", 32'({low_ref, stop_dec}), 32'h2);
        lim(6'h03);
        chk("isel_stop", 32'({low_ref, stop_dec, up_ok}), 32'h2);
        lim(6'h00);
        chk("isel_clr", 32'(up_ok), 32'h1);
        rd_chk("irq_lim", HSF_OFS_IRQ, 32'h6);
    endtask : t_limit
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (12) @(posedge core_clk_in);
        rst_in <= 1'b0;
        cyc(1);
        t_regs();
        t_dir();
        t_slack();
        t_limit();
        end_sim();
    end
    initial begin
        #50000;
        bad_count++;
        end_sim();
    end
endmodule : tb_top
bind hsf_top hsf_props u_props (.*);
